// ---- gpm_defines.svh ----
`ifndef GPM_DEFINES_SVH
`define GPM_DEFINES_SVH

// register byte addresses
`define GPM_P2_POL_ADDR      32'h400200A4
`define GPM_P2_IRQA_ADDR     32'h400200A8
`define GPM_P2_IRQB_ADDR     32'h400200AC
`define GPM_P2_STAT_ADDR     32'h400200B0
`define GPM_P3_FUNC_ADDR     32'h400200C0
`define GPM_P3_DRV_ADDR      32'h400200C4
`define GPM_P3_PULL_ADDR     32'h400200C8

// reset values
`define GPM_P2_RST           16'h0000
`define GPM_P3_FUNC_RST      32'h00000000
`define GPM_P3_BIT_RST       15'h0000

// writable field masks; reserved bits read as zero
`define GPM_P3_FUNC_MASK     32'h3FFFFFFF
`define GPM_P3_BIT_MASK      15'h7FFF

// field width and positions
`define GPM_FN_W             2
`define GPM_P2_LSB           0
`define GPM_P3_LSB           0

// pins on which each alternate code is a listed encoding
`define GPM_ALT1_PINS        15'h3FFF
`define GPM_ALT2_PINS        15'h70C0
`define GPM_ALT3_PINS        15'h00F0

// bus responses
`define GPM_RESP_OKAY        2'h0
`define GPM_RESP_SLVERR      2'h2

`endif

// ---- gpm_pkg.sv ----
package gpm_pkg;

    typedef enum logic [1:0] {
        GPM_FN_GPIO = 2'h0,
        GPM_FN_ALT1 = 2'h1,
        GPM_FN_ALT2 = 2'h2,
        GPM_FN_ALT3 = 2'h3
    } gpm_fn_type;

    typedef struct packed {
        logic [31:0] awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic        arvalid;
        logic        rready;
    } gpm_axi_req_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } gpm_axi_rsp_type;

    // index 0..2 stands for codes 01, 10, 11
    typedef logic [2:0][14:0] gpm_alt_type;

    typedef struct packed {
        logic [14:0] out;
        logic [14:0] oe;
        logic [14:0] pull;
    } gpm_pad_type;

endpackage : gpm_pkg

// ---- gpm_top.sv ----
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpm_defines.svh"

module gpm_top
    import gpm_pkg::*;
#(
    parameter int P2_W = 16,
    parameter int P3_W = 15
) (
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            srst,
    // register bus
    input  wire gpm_axi_req_type axi_req,
    output var  gpm_axi_rsp_type axi_rsp,
    // port 2 pins and interrupts
    input  wire logic [P2_W-1:0] p2_pin_i,
    output var  logic            irq_a,
    output var  logic            irq_b,
    output var  logic            irq,
    // port 3 pads
    input  wire logic [P3_W-1:0] p3_pad_in,
    output var  gpm_pad_type     p3_pad,
    // port 3 gpio data
    input  wire logic [P3_W-1:0] p3_gpio_out,
    output var  logic [P3_W-1:0] p3_gpio_in,
    // port 3 peripheral signals
    input  wire gpm_alt_type     alt_out,
    input  wire gpm_alt_type     alt_oe,
    output var  gpm_alt_type     alt_in
);

    // ---- bus state
    logic            aw_held_r,  aw_held_nxt;
    logic            w_held_r,   w_held_nxt;
    logic [31:0]     awaddr_r,   awaddr_nxt;
    logic [31:0]     wdata_r,    wdata_nxt;
    logic [3:0]      wstrb_r,    wstrb_nxt;
    gpm_axi_rsp_type rsp_r,      rsp_nxt;
    logic            wr_fire;
    logic            wr_hit;

    // ---- register state
    logic [P2_W-1:0] pol_r,      pol_nxt;
    logic [P2_W-1:0] mask_a_r,   mask_a_nxt;
    logic [P2_W-1:0] mask_b_r,   mask_b_nxt;
    logic [P2_W-1:0] stat_r,     stat_nxt;
    logic [31:0]     func_r,     func_nxt;
    logic [P3_W-1:0] drv_r,      drv_nxt;
    logic [P3_W-1:0] pull_r,     pull_nxt;
    logic [31:0]     be;
    logic [P2_W-1:0] clr_bits;

    // ---- pin state
    logic [P2_W-1:0] p2_s1_r,    p2_s2_r,   p2_prev_r;
    logic [P2_W-1:0] edge_hit;
    logic [P3_W-1:0] p3_s1_r,    p3_s2_r;
    gpm_pad_type     pad_r,      pad_nxt;
    gpm_alt_type     alt_in_r,   alt_in_nxt;
    logic [P3_W-1:0] gin_r;
    logic            irq_a_r,    irq_b_r,   irq_r;
    logic            irq_a_nxt,  irq_b_nxt;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [31:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction : merge

    // ---- AXI4-Lite slave
    // one write and one read in flight; address and data taken in either order
    always_comb begin
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        rsp_nxt     = rsp_r;
        wr_fire     = 1'b0;
        if (axi_req.awvalid && rsp_r.awready) begin
            aw_held_nxt = 1'b1;
            awaddr_nxt  = axi_req.awaddr;
        end
        if (axi_req.wvalid && rsp_r.wready) begin
            w_held_nxt = 1'b1;
            wdata_nxt  = axi_req.wdata;
            wstrb_nxt  = axi_req.wstrb;
        end
        if (rsp_r.bvalid && axi_req.bready) begin
            rsp_nxt.bvalid = 1'b0;
        end
        if (aw_held_r && w_held_r && !rsp_r.bvalid) begin
            wr_fire        = 1'b1;
            aw_held_nxt    = 1'b0;
            w_held_nxt     = 1'b0;
            rsp_nxt.bvalid = 1'b1;
            rsp_nxt.bresp  = wr_hit ? `GPM_RESP_OKAY : `GPM_RESP_SLVERR;
        end
        rsp_nxt.awready = !aw_held_nxt && !rsp_nxt.bvalid;
        rsp_nxt.wready  = !w_held_nxt && !rsp_nxt.bvalid;
        if (rsp_r.rvalid && axi_req.rready) begin
            rsp_nxt.rvalid = 1'b0;
        end
        if (axi_req.arvalid && rsp_r.arready) begin
            rsp_nxt.rvalid = 1'b1;
            rsp_nxt.rresp  = `GPM_RESP_OKAY;
            case (axi_req.araddr)
                `GPM_P2_POL_ADDR:  rsp_nxt.rdata = {16'h0000, pol_r};
                `GPM_P2_IRQA_ADDR: rsp_nxt.rdata = {16'h0000, mask_a_r};
                `GPM_P2_IRQB_ADDR: rsp_nxt.rdata = {16'h0000, mask_b_r};
                `GPM_P2_STAT_ADDR: rsp_nxt.rdata = {16'h0000, stat_r};
                `GPM_P3_FUNC_ADDR: rsp_nxt.rdata = func_r;
                `GPM_P3_DRV_ADDR:  rsp_nxt.rdata = {17'h00000, drv_r};
                `GPM_P3_PULL_ADDR: rsp_nxt.rdata = {17'h00000, pull_r};
                default: begin
                    rsp_nxt.rdata = 32'h00000000;
                    rsp_nxt.rresp = `GPM_RESP_SLVERR;
                end
            endcase
        end
        rsp_nxt.arready = !rsp_nxt.rvalid;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 32'h00000000;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            rsp_r     <= '0;
        end else begin
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            awaddr_r  <= awaddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            rsp_r     <= rsp_nxt;
        end
    end

    assign axi_rsp = rsp_r;

    // ---- register file
    always_comb begin
        be         = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
        pol_nxt    = pol_r;
        mask_a_nxt = mask_a_r;
        mask_b_nxt = mask_b_r;
        func_nxt   = func_r;
        drv_nxt    = drv_r;
        pull_nxt   = pull_r;
        clr_bits   = '0;
        wr_hit     = 1'b1;
        case (awaddr_r)
            `GPM_P2_POL_ADDR: begin
                if (wr_fire) pol_nxt = (pol_r & ~be[P2_W-1:0])
                                     | (wdata_r[P2_W-1:0] & be[P2_W-1:0]);
            end
            `GPM_P2_IRQA_ADDR: begin
                if (wr_fire) mask_a_nxt = (mask_a_r & ~be[P2_W-1:0])
                                        | (wdata_r[P2_W-1:0] & be[P2_W-1:0]);
            end
            `GPM_P2_IRQB_ADDR: begin
                if (wr_fire) mask_b_nxt = (mask_b_r & ~be[P2_W-1:0])
                                        | (wdata_r[P2_W-1:0] & be[P2_W-1:0]);
            end
            `GPM_P2_STAT_ADDR: begin
                if (wr_fire) clr_bits = wdata_r[P2_W-1:0] & be[P2_W-1:0];
            end
            `GPM_P3_FUNC_ADDR: begin
                if (wr_fire) func_nxt = merge(func_r, wdata_r, be)
                                        & `GPM_P3_FUNC_MASK;
            end
            `GPM_P3_DRV_ADDR: begin
                if (wr_fire) drv_nxt = ((drv_r & ~be[P3_W-1:0])
                                     | (wdata_r[P3_W-1:0] & be[P3_W-1:0]))
                                     & `GPM_P3_BIT_MASK;
            end
            `GPM_P3_PULL_ADDR: begin
                if (wr_fire) pull_nxt = ((pull_r & ~be[P3_W-1:0])
                                      | (wdata_r[P3_W-1:0] & be[P3_W-1:0]))
                                      & `GPM_P3_BIT_MASK;
            end
            default: wr_hit = 1'b0;
        endcase
        // a new edge wins over a clear in the same cycle; masks play no part
        stat_nxt = (stat_r & ~clr_bits) | edge_hit;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pol_r    <= `GPM_P2_RST;
            mask_a_r <= `GPM_P2_RST;
            mask_b_r <= `GPM_P2_RST;
            stat_r   <= `GPM_P2_RST;
            func_r   <= `GPM_P3_FUNC_RST;
            drv_r    <= `GPM_P3_BIT_RST;
            pull_r   <= `GPM_P3_BIT_RST;
        end else begin
            pol_r    <= pol_nxt;
            mask_a_r <= mask_a_nxt;
            mask_b_r <= mask_b_nxt;
            stat_r   <= stat_nxt;
            func_r   <= func_nxt;
            drv_r    <= drv_nxt;
            pull_r   <= pull_nxt;
        end
    end

    // ---- port 2 edge capture and interrupts
    // prev starts at zero, so a pin already high at release looks like a rising edge
    always_comb begin
        edge_hit  = (pol_r & p2_s2_r & ~p2_prev_r)
                  | (~pol_r & ~p2_s2_r & p2_prev_r);
        irq_a_nxt = |(stat_nxt & mask_a_nxt);
        irq_b_nxt = |(stat_nxt & mask_b_nxt);
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            p2_s1_r   <= '0;
            p2_s2_r   <= '0;
            p2_prev_r <= '0;
            irq_a_r   <= 1'b0;
            irq_b_r   <= 1'b0;
            irq_r     <= 1'b0;
        end else begin
            p2_s1_r   <= p2_pin_i;
            p2_s2_r   <= p2_s1_r;
            p2_prev_r <= p2_s2_r;
            irq_a_r   <= irq_a_nxt;
            irq_b_r   <= irq_b_nxt;
            irq_r     <= irq_a_nxt | irq_b_nxt;
        end
    end

    assign irq_a = irq_a_r;
    assign irq_b = irq_b_r;
    assign irq   = irq_r;

    // ---- port 3 function multiplexer
    // code index c-1: 14 audio word clk / 13 data,beep N / 12 bit clk,beep P
    // 11..8 LCD seg 32..29; 7 UART rx, timer C, SPI1 CS; 6 UART tx, timer B, SPI1 MOSI
    // 5 I2C SDA, SPI1 MISO; 4 I2C SCL, SPI1 SCLK; 3..0 SPI0 CS, MOSI, MISO, SCLK
    // unlisted codes fall back to gpio so a bad setting cannot drive a stray signal
    localparam logic [2:0][14:0] ALT_PINS = {`GPM_ALT3_PINS, `GPM_ALT2_PINS, `GPM_ALT1_PINS};

    always_comb begin
        gpm_fn_type fn;
        logic       alt_ok;
        logic [1:0] ci;
        fn         = GPM_FN_GPIO;
        alt_ok     = 1'b0;
        ci         = 2'h0;
        pad_nxt    = '0;
        alt_in_nxt = '0;
        for (int i = 0; i < P3_W; i++) begin
            fn     = gpm_fn_type'(func_r[i*`GPM_FN_W +: `GPM_FN_W]);
            ci     = 2'(fn) - 2'h1;
            alt_ok = (fn != GPM_FN_GPIO) && ALT_PINS[ci][i];
            if (alt_ok) begin
                pad_nxt.out[i]      = alt_out[ci][i];
                pad_nxt.oe[i]       = alt_oe[ci][i];
                alt_in_nxt[ci][i]   = p3_s2_r[i];
            end else begin
                pad_nxt.out[i]      = p3_gpio_out[i];
                pad_nxt.oe[i]       = drv_r[i];
            end
            pad_nxt.pull[i] = pull_r[i];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            p3_s1_r  <= '0;
            p3_s2_r  <= '0;
            pad_r    <= '0;
            alt_in_r <= '0;
            gin_r    <= '0;
        end else begin
            p3_s1_r  <= p3_pad_in;
            p3_s2_r  <= p3_s1_r;
            pad_r    <= pad_nxt;
            alt_in_r <= alt_in_nxt;
            gin_r    <= p3_s2_r;
        end
    end

    assign p3_pad     = pad_r;
    assign alt_in     = alt_in_r;
    assign p3_gpio_in = gin_r;

endmodule : gpm_top
`default_nettype wire

// ---- gpm_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpm_monitor
    import gpm_pkg::*;
(
    // clock and reset
    input  wire logic            ref_clk,
    input  wire logic            srst,
    // register bus
    input  wire gpm_axi_req_type axi_req,
    input  wire gpm_axi_rsp_type axi_rsp,
    // interrupts
    input  wire logic            irq_a,
    input  wire logic            irq_b,
    input  wire logic            irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    chk_irq_merge: assert property (irq == (irq_a | irq_b))
        else $error("merged line differs");
    // a line may only drop around a bus write; one cycle of slack for the update
    chk_irqa_sticky: assert property (irq_a ##1 !axi_rsp.bvalid [*2] |-> irq_a)
        else $error("line a dropped without a write");
    chk_irqb_sticky: assert property (irq_b ##1 !axi_rsp.bvalid [*2] |-> irq_b)
        else $error("line b dropped without a write");
    chk_aw_busy: assert property (axi_req.awvalid && axi_rsp.awready |=> !axi_rsp.awready)
        else $error("second write address taken");
    chk_b_soon: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |-> ##[1:2] axi_rsp.bvalid) else $error("write answer late");
    chk_b_drop: assert property (axi_rsp.bvalid && axi_req.bready |=> !axi_rsp.bvalid)
        else $error("write answer repeated");
    chk_r_soon: assert property (axi_req.arvalid && axi_rsp.arready |-> ##[1:2] axi_rsp.rvalid)
        else $error("read answer late");
    chk_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
        else $error("read taken while answer pending");
endmodule : gpm_monitor
`default_nettype wire

// ---- gpm_pads.sv ----
`timescale 1ns/1ps
`default_nettype none
module gpm_pads
    import gpm_pkg::*;
(
    // clock
    input  wire logic        ref_clk,
    // pad side of the block
    input  wire gpm_pad_type p3_pad,
    output var  logic [14:0] p3_pad_in
);
    logic [14:0] last_r = '0;
    always_ff @(posedge ref_clk) begin
        last_r <= p3_pad_in;
    end
    // a floating pin flips each cycle so a stale level never passes for data
    always_comb begin
        for (int i = 0; i < 15; i++) begin
            p3_pad_in[i] = p3_pad.oe[i] ? p3_pad.out[i] : (p3_pad.pull[i] | ~last_r[i]);
        end
    end
endmodule : gpm_pads
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
    import gpm_pkg::*;
;
    typedef struct packed {
        logic [31:0] a;
        logic [31:0] w;
        logic [31:0] e;
    } gpm_row_type;
    localparam logic [31:0] BASE = 32'h40020000;
    // offset, value written, value read back
    localparam gpm_row_type ROWS [7] = '{
        '{32'hA4, 32'hFFFFFFFF, 32'h0000FFFF}, '{32'hA8, 32'hFFFFFFFF, 32'h0000FFFF},
        '{32'hAC, 32'hFFFFFFFF, 32'h0000FFFF}, '{32'hB0, 32'h00000000, 32'h00000000},
        '{32'hC0, 32'hE5555555, 32'h25555555}, '{32'hC4, 32'hFFFFFFFF, 32'h00007FFF},
        '{32'hC8, 32'hFFFFFFFF, 32'h00007FFF}};
    logic            ref_clk     = 1'b0;
    logic            srst        = 1'b1;
    gpm_axi_req_type axi_req     = '0;
    gpm_axi_rsp_type axi_rsp;
    logic [15:0]     p2_pin_i    = '0;
    logic [14:0]     p3_gpio_out = '0;
    logic [14:0]     p3_pad_in;
    logic [14:0]     p3_gpio_in;
    logic            irq_a;
    logic            irq_b;
    logic            irq;
    gpm_pad_type     p3_pad;
    gpm_alt_type     alt_out     = '0;
    gpm_alt_type     alt_oe      = '1;
    gpm_alt_type     alt_in;
    gpm_alt_type     t;
    logic [31:0]     f;
    logic [14:0]     lst [3]     = '{15'h3FFF, 15'h70C0, 15'h00F0};
    int              n_errors    = 0;
    int              checked     = 0;

    gpm_top u_gpm_top (.ref_clk, .srst, .axi_req, .axi_rsp, .p2_pin_i, .irq_a, .irq_b, .irq,
        .p3_pad_in, .p3_pad, .p3_gpio_out, .p3_gpio_in, .alt_out, .alt_oe, .alt_in);
    gpm_pads u_gpm_pads (.ref_clk, .p3_pad, .p3_pad_in);

    initial forever #25 ref_clk = ~ref_clk;

    task automatic cmp(input logic [47:0] g, input logic [47:0] e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        axi_req.awaddr  <= BASE + a;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hF;
        axi_req.awvalid <= 1'b1;
        axi_req.wvalid  <= 1'b1;
        axi_req.bready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            axi_req.awvalid <= axi_req.awvalid & ~axi_rsp.awready;
            axi_req.wvalid  <= axi_req.wvalid & ~axi_rsp.wready;
        end while (axi_rsp.bvalid !== 1'b1);
        axi_req.bready <= 1'b0;
        cmp(axi_rsp.bresp, er);
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] er);
        axi_req.araddr  <= BASE + a;
        axi_req.arvalid <= 1'b1;
        axi_req.rready  <= 1'b1;
        do begin
            @(posedge ref_clk);
            axi_req.arvalid <= axi_req.arvalid & ~axi_rsp.arready;
        end while (axi_rsp.rvalid !== 1'b1);
        axi_req.rready <= 1'b0;
        cmp({axi_rsp.rresp, axi_rsp.rdata}, {er, e});
        @(posedge ref_clk);
    endtask : rd

    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        foreach (ROWS[i]) begin
            rd(ROWS[i].a, '0, 2'h0);
            wr(ROWS[i].a, ROWS[i].w, 2'h0);
            rd(ROWS[i].a, ROWS[i].e, 2'h0);
        end
        // unmapped word between status and function select
        wr(32'hB4, '1, 2'h2);
        rd(32'hB4, '0, 2'h2);
        $display("test registers done");
        p3_gpio_out <= 15'h2AAA;
        wr(32'hC0, '0, 2'h0);
        repeat (6) @(posedge ref_clk);
        cmp({p3_pad.oe, p3_pad.pull}, 30'h3FFFFFFF);
        cmp({p3_pad.out, p3_gpio_in}, {15'h2AAA, 15'h2AAA});
        wr(32'hC4, '0, 2'h0);
        wr(32'hC8, '0, 2'h0);
        repeat (3) @(posedge ref_clk);
        cmp({p3_pad.oe, p3_pad.pull}, '0);
        $display("test pads done");
        // drivers stay off, so only the selected peripheral's enable can turn a pad on
        p3_gpio_out <= '0;
        for (int c = 1; c < 4; c++) begin
            f = '0;
            t = '0;
            // only listed codes are ever programmed
            for (int p = 0; p < 15; p++) begin
                if (lst[c-1][p]) f[2*p +: 2] = c[1:0];
            end
            t[c-1] = '1;
            alt_out <= t;
            alt_oe  <= t;
            wr(32'hC0, f, 2'h0);
            repeat (6) @(posedge ref_clk);
            t[c-1] = lst[c-1];
            cmp(p3_pad.out, lst[c-1]);
            cmp(p3_pad.oe, lst[c-1]);
            cmp(alt_in, t);
        end
        wr(32'hC0, '0, 2'h0);
        $display("test mux done");
        wr(32'hA4, 32'h1, 2'h0);
        wr(32'hA8, 32'h1, 2'h0);
        wr(32'hAC, 32'h2, 2'h0);
        p2_pin_i <= 16'h0001;
        repeat (8) @(posedge ref_clk);
        rd(32'hB0, 32'h1, 2'h0);
        cmp({irq_a, irq_b, irq}, 3'b101);
        p2_pin_i <= 16'h0006;
        repeat (8) @(posedge ref_clk);
        rd(32'hB0, 32'h1, 2'h0);
        p2_pin_i <= 16'h0000;
        repeat (8) @(posedge ref_clk);
        rd(32'hB0, 32'h7, 2'h0);
        cmp({irq_a, irq_b, irq}, 3'b111);
        wr(32'hB0, 32'h1, 2'h0);
        rd(32'hB0, 32'h6, 2'h0);
        cmp({irq_a, irq_b, irq}, 3'b011);
        wr(32'hB0, 32'h0, 2'h0);
        rd(32'hB0, 32'h6, 2'h0);
        wr(32'hAC, 32'h0, 2'h0);
        cmp({irq_a, irq_b, irq}, 3'b000);
        $display("test events done");
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        rd(32'hB0, '0, 2'h0);
        rd(32'hA8, '0, 2'h0);
        $display("test reset done");
        tally_and_finish();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge ref_clk);
        n_errors++;
        tally_and_finish();
    end
endmodule : testbench

bind gpm_top gpm_monitor u_gpm_monitor (.ref_clk, .srst, .axi_req, .axi_rsp, .irq_a, .irq_b, .irq);
`default_nettype wire
